// ==== bcdp_regs.vh ====
// register offsets, field positions, reset values and timing counts for the control front end
`ifndef BCDP_REGS_VH
`define BCDP_REGS_VH

// register byte offsets
`define BCDP_ADDR_W            8
`define BCDP_OFF_BASE          8'h00
`define BCDP_OFF_ID            8'h04
`define BCDP_OFF_CONV          8'h08

// base_control fields
`define BCDP_BASE_REAR_A       0
`define BCDP_BASE_REAR_B       1
`define BCDP_BASE_MINT_EN      4
`define BCDP_BASE_FINT         5
`define BCDP_BASE_PGM_EN       16
`define BCDP_BASE_SCLK         17
`define BCDP_BASE_AUX_SEL      18
`define BCDP_BASE_SDATA        19
`define BCDP_BASE_SDATA_REL    20
`define BCDP_BASE_RESET        21'h000000

// board_identification fields
`define BCDP_ID_DIP_LSB        0
`define BCDP_ID_REV_LSB        8
`define BCDP_ID_PEND           16
`define BCDP_ID_SDATA_STORED   19

// converter_command_port fields
`define BCDP_CONV_DATA_W       16
`define BCDP_CONV_BUSY         16
`define BCDP_CONV_RESET        16'h0000

// timing: system clock period and serial bit time, both in ns
`define BCDP_CLK_NS            5
`define BCDP_SER_BIT_NS        50
`define BCDP_SER_HALF_CYC      (`BCDP_SER_BIT_NS / 2 / `BCDP_CLK_NS)

`endif

// ==== bcdp_dac_serial.v ====
// serial shifter that sends one 16-bit command to the octal converter
`include "bcdp_regs.vh"

module bcdp_dac_serial #(
  parameter WIDTH    = `BCDP_CONV_DATA_W,
  parameter HALF_CYC = `BCDP_SER_HALF_CYC
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             rst,
  // command side
  input  wire             start,
  input  wire [WIDTH-1:0] word,
  output wire             busy,
  // serial pins
  output reg              dac_cs_n,
  output reg              dac_sclk,
  output reg              dac_din
);

  localparam ST_IDLE  = 2'd0;
  localparam ST_SETUP = 2'd1;
  localparam ST_SHIFT = 2'd2;
  localparam ST_END   = 2'd3;

  // last divider count of a half bit, cut to the divider width on purpose
  localparam [7:0] HALF_LAST = HALF_CYC[7:0] - 8'h01;

  reg [1:0]       state_q;
  reg [7:0]       div_q;
  reg [WIDTH-1:0] shift_q;
  reg [4:0]       bits_q;
  wire            half_tick;

  // half-bit enable: two per 20 MHz bit at the system rate
  assign half_tick = (div_q == HALF_LAST);
  assign busy      = (state_q != ST_IDLE);

  // shifter; a new start restarts the frame so the last write always wins
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q  <= ST_IDLE;
      div_q    <= 8'h00;
      shift_q  <= {WIDTH{1'b0}};
      bits_q   <= 5'h00;
      dac_cs_n <= 1'b1;
      dac_sclk <= 1'b0;
      dac_din  <= 1'b0;
    end else if (start) begin
      state_q  <= ST_SETUP;
      div_q    <= 8'h00;
      shift_q  <= word;
      bits_q   <= WIDTH[4:0] - 5'h01;
      dac_cs_n <= 1'b0;
      dac_sclk <= 1'b0;
      dac_din  <= word[WIDTH-1]; // msb first
    end else if (state_q != ST_IDLE) begin
      div_q <= half_tick ? 8'h00 : div_q + 8'h01;
      if (half_tick) begin
        case (state_q)
          ST_SETUP: state_q <= ST_SHIFT; // select setup before first edge
          ST_SHIFT: begin
            if (!dac_sclk) begin
              dac_sclk <= 1'b1; // converter samples on this edge
            end else begin
              dac_sclk <= 1'b0;
              if (bits_q == 5'h00) begin
                state_q <= ST_END;
              end else begin
                bits_q  <= bits_q - 5'h01;
                shift_q <= {shift_q[WIDTH-2:0], 1'b0};
                dac_din <= shift_q[WIDTH-2];
              end
            end
          end
          ST_END: begin
            dac_cs_n <= 1'b1;
            state_q  <= ST_IDLE;
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

endmodule // bcdp_dac_serial

// ==== bcdp_top.v ====
// host control front end: base control, identification and converter command port
// Operation
// - base bits 19..16 drive synth data, select, serial clock and program enable
// - base bit 19 reads the live synth data line; stored value shows at next word
// - base bits 0 and 1 drive the two rear connector outputs
// - master interrupt enable gates every interrupt request
// - force bit raises a request while set and enabled; cleared only by writing zero or by reset
// - identification bit 16 shows any masked interrupt request pending
// - identification bits 15..8 return the fixed logic revision code
// - identification bits 7..0 return the live dip switch
// - a write to the converter port stores the word and starts sending it
// - converter port bit 16 reads high while a transfer is running
// - converter port bits 15..0 return the last command word sent
// - command word: control code in 15..12, msb-aligned data in 11..0
// - the serial port shifts 16 bits at 20 MHz, about 0.8 us per word
// - base at 0x00, identification at 0x04, converter port at 0x08
`include "bcdp_regs.vh"

module bcdp_top #(
  parameter [7:0] LOGIC_REV = 8'h01, // arbitrary value, set per release
  parameter       HALF_CYC  = `BCDP_SER_HALF_CYC
) (
  // clock and reset
  input  wire                    clk_sys,
  input  wire                    rst,
  // register port
  input  wire [`BCDP_ADDR_W-1:0] reg_addr,
  input  wire                    reg_wr,
  input  wire [31:0]             reg_wdata,
  input  wire                    reg_rd,
  output reg  [31:0]             reg_rdata,
  output reg                     reg_rvalid,
  // synthesizer programming lines
  output wire                    synth_data_o,
  output wire                    synth_data_oe_n,
  input  wire                    synth_data_i,
  output wire                    synth_sclk,
  output wire                    synth_aux_select_bit,
  output wire                    synth_pgm_en,
  // rear connector spares
  output wire                    rear_out_a,
  output wire                    rear_out_b,
  // board switch and interrupt
  input  wire [7:0]              dip_sw,
  output wire                    int_req,
  // converter serial port
  output wire                    dac_cs_n,
  output wire                    dac_sclk,
  output wire                    dac_din
);

  // address decode
  wire sel_base;
  wire sel_id;
  wire sel_conv;

  assign sel_base = (reg_addr == `BCDP_OFF_BASE);
  assign sel_id   = (reg_addr == `BCDP_OFF_ID);
  assign sel_conv = (reg_addr == `BCDP_OFF_CONV);

  // stored control state
  reg  [20:0] base_q;
  reg  [15:0] conv_word_q;
  wire        conv_start;
  wire        conv_busy;

  // base control holds all software bits; unused bits are never stored
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      base_q <= `BCDP_BASE_RESET; // force bit and enable reset to zero
    end else if (reg_wr && sel_base) begin
      base_q[`BCDP_BASE_REAR_A]     <= reg_wdata[`BCDP_BASE_REAR_A];
      base_q[`BCDP_BASE_REAR_B]     <= reg_wdata[`BCDP_BASE_REAR_B];
      base_q[`BCDP_BASE_MINT_EN]    <= reg_wdata[`BCDP_BASE_MINT_EN];
      base_q[`BCDP_BASE_FINT]       <= reg_wdata[`BCDP_BASE_FINT];
      base_q[`BCDP_BASE_PGM_EN]     <= reg_wdata[`BCDP_BASE_PGM_EN];
      base_q[`BCDP_BASE_SCLK]       <= reg_wdata[`BCDP_BASE_SCLK];
      base_q[`BCDP_BASE_AUX_SEL]    <= reg_wdata[`BCDP_BASE_AUX_SEL];
      base_q[`BCDP_BASE_SDATA]      <= reg_wdata[`BCDP_BASE_SDATA];
      base_q[`BCDP_BASE_SDATA_REL]  <= reg_wdata[`BCDP_BASE_SDATA_REL];
    end
  end

  // synthesizer lines are plain register bits so software bit-bangs them
  assign synth_data_o         = base_q[`BCDP_BASE_SDATA];
  assign synth_aux_select_bit = base_q[`BCDP_BASE_AUX_SEL];
  assign synth_sclk           = base_q[`BCDP_BASE_SCLK];
  assign synth_pgm_en         = base_q[`BCDP_BASE_PGM_EN];
  // release the data line for read-back; low enable means we drive
  assign synth_data_oe_n      = base_q[`BCDP_BASE_SDATA_REL];

  // rear spares follow the written value
  assign rear_out_a = base_q[`BCDP_BASE_REAR_A];
  assign rear_out_b = base_q[`BCDP_BASE_REAR_B];

  // interrupt: force is the only local source, gated by the master enable
  wire int_pend;

  assign int_pend = base_q[`BCDP_BASE_MINT_EN] & base_q[`BCDP_BASE_FINT];
  assign int_req  = int_pend;

  // converter command capture; no busy check, a new write restarts the frame
  assign conv_start = reg_wr && sel_conv;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      conv_word_q <= `BCDP_CONV_RESET;
    end else if (conv_start) begin
      conv_word_q <= reg_wdata[15:0]; // word layout is software's job
    end
  end

  // serial shifter
  bcdp_dac_serial #(
    .WIDTH    (`BCDP_CONV_DATA_W),
    .HALF_CYC (HALF_CYC)
  ) u_dac_serial (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .start    (conv_start),
    .word     (reg_wdata[15:0]),
    .busy     (conv_busy),
    .dac_cs_n (dac_cs_n),
    .dac_sclk (dac_sclk),
    .dac_din  (dac_din)
  );

  // read multiplexer; unmapped offsets read zero
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h00000000;
    if (sel_base) begin
      rd_mux[`BCDP_BASE_REAR_A]  = base_q[`BCDP_BASE_REAR_A];
      rd_mux[`BCDP_BASE_REAR_B]  = base_q[`BCDP_BASE_REAR_B];
      rd_mux[`BCDP_BASE_MINT_EN] = base_q[`BCDP_BASE_MINT_EN];
      rd_mux[`BCDP_BASE_FINT]    = base_q[`BCDP_BASE_FINT];
      rd_mux[`BCDP_BASE_PGM_EN]  = base_q[`BCDP_BASE_PGM_EN];
      rd_mux[`BCDP_BASE_SCLK]    = base_q[`BCDP_BASE_SCLK];
      rd_mux[`BCDP_BASE_AUX_SEL] = base_q[`BCDP_BASE_AUX_SEL];
      rd_mux[`BCDP_BASE_SDATA]   = synth_data_i; // live line, not the flop
      rd_mux[`BCDP_BASE_SDATA_REL] = base_q[`BCDP_BASE_SDATA_REL];
    end else if (sel_id) begin
      rd_mux[`BCDP_ID_DIP_LSB +: 8] = dip_sw;          // unlatched
      rd_mux[`BCDP_ID_REV_LSB +: 8] = LOGIC_REV;
      rd_mux[`BCDP_ID_PEND]         = int_pend;
      rd_mux[`BCDP_ID_SDATA_STORED] = base_q[`BCDP_BASE_SDATA];
    end else if (sel_conv) begin
      rd_mux[15:0]            = conv_word_q;
      rd_mux[`BCDP_CONV_BUSY] = conv_busy;
    end
  end

  // registered read data, valid one cycle after the strobe
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata  <= 32'h00000000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

endmodule // bcdp_top

// ==== bcdp_checker.sv ====
// concurrent checks on the control front end ports
module bcdp_checker #(
  parameter [7:0] LOGIC_REV = 8'h01, // arbitrary value
  parameter       HALF_CYC  = 5
) (
  // clock and reset
  input wire        clk_sys,
  input wire        rst,
  // register port
  input wire [7:0]  reg_addr,
  input wire        reg_wr,
  input wire [31:0] reg_wdata,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire        reg_rvalid,
  // board pins
  input wire        synth_data_o,
  input wire        synth_data_i,
  input wire        synth_sclk,
  input wire        synth_aux_select_bit,
  input wire        synth_pgm_en,
  input wire        rear_out_a,
  input wire        rear_out_b,
  input wire [7:0]  dip_sw,
  input wire        int_req,
  input wire        dac_cs_n,
  input wire        dac_sclk,
  input wire        dac_din
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FR = 34 * HALF_CYC;
  wire wc = reg_wr && reg_addr == 8'h08;
  int  cnt_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // select-low cycles; a rewrite restarts the frame so it restarts the count
  always @(posedge clk_sys or posedge rst)
    if (rst) cnt_q <= 0;
    else if (wc) cnt_q <= 0;
    else if (!dac_cs_n) cnt_q <= cnt_q + 1;
  a_synth_lines: assert property (reg_wr && reg_addr == 8'h00 |=>
    {synth_data_o, synth_aux_select_bit, synth_sclk, synth_pgm_en} == $past(reg_wdata[19:16]))
    else $error("synth lines differ from written bits");
  a_rear_out: assert property (reg_wr && reg_addr == 8'h00 |=>
    {rear_out_b, rear_out_a} == $past(reg_wdata[1:0])) else $error("rear outputs wrong");
  a_int_gate: assert property (reg_wr && reg_addr == 8'h00 |=>
    int_req == ($past(reg_wdata[4]) && $past(reg_wdata[5]))) else $error("int gating wrong");
  a_live_sdata: assert property (reg_rd && reg_addr == 8'h00 |=>
    reg_rdata[19] == $past(synth_data_i)) else $error("base bit 19 not live line");
  a_id_fields: assert property (reg_rd && reg_addr == 8'h04 |=>
    reg_rdata[16:0] == {$past(int_req), LOGIC_REV, $past(dip_sw)}) else $error("id fields wrong");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h0C |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_read_valid: assert property (reg_rd |=> reg_rvalid ##1 (reg_rvalid == $past(reg_rd)))
    else $error("read valid timing wrong");
  a_busy_read: assert property (reg_rd && reg_addr == 8'h08 |=>
    reg_rdata[16] == !$past(dac_cs_n)) else $error("busy bit differs from frame");
  a_conv_start: assert property (wc |=> !dac_cs_n && dac_din == $past(reg_wdata[15]))
    else $error("frame did not start with msb");
  a_frame_len: assert property ($rose(dac_cs_n) |-> cnt_q == FR)
    else $error("frame length wrong");
  a_sclk_idle: assert property (dac_cs_n |-> !dac_sclk)
    else $error("serial clock runs while deselected");
endmodule // bcdp_checker

// ==== bcdp_dac_model.sv ====
// converter and synthesizer readback model on the far side of the pins
module bcdp_dac_model (
  // converter pins
  input  wire         cs_n,
  input  wire         sclk,
  input  wire         din,
  // synthesizer clock and readback
  input  wire         synth_sclk,
  output logic        pll_bit,
  // last frame seen
  output logic [15:0] word,
  output int          frames
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] sh;
  int          n;
  initial begin
    pll_bit = 1'b0;
    word = 16'h0000;
    frames = 0;
    n = 0;
  end
  // msb first, sampled on rising clock while selected
  always @(posedge sclk) if (!cs_n) begin
    sh = {sh[14:0], din};
    n = n + 1;
  end
  always @(negedge cs_n) n = 0;
  // keeps the last 16 bits, so a restarted frame lands whole; code in 15..12
  always @(posedge cs_n) if (n >= 16) begin
    word = sh;
    frames = frames + 1;
  end
  // readback changes every programming clock, so a stale register value shows
  always @(posedge synth_sclk) pll_bit = ~pll_bit;
endmodule // bcdp_dac_model

// ==== bcdp_top_tb.sv ====
// register level bench for the control front end
module bcdp_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam HC = 2;
  logic        clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00, dip_sw = 8'h3C;
  logic [31:0] reg_wdata = 32'h0;
  wire  [31:0] reg_rdata;
  wire  [15:0] mword;
  wire         reg_rvalid, sd_o, sd_oe_n, sd_i, s_sclk, s_aux, s_pgm, ra, rb;
  wire         int_req, cs_n, sclk, din, pll_bit;
  int          frames, failures = 0, cmp_count = 0, cyc = 0, i, k, f0;
  // shared data line: device drives while its enable is low
  assign sd_i = sd_oe_n ? pll_bit : sd_o;
  bcdp_top #(.LOGIC_REV(8'h5A), .HALF_CYC(HC)) uut (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .synth_data_o(sd_o), .synth_data_oe_n(sd_oe_n), .synth_data_i(sd_i), .synth_sclk(s_sclk),
    .synth_aux_select_bit(s_aux), .synth_pgm_en(s_pgm), .rear_out_a(ra), .rear_out_b(rb),
    .dip_sw(dip_sw), .int_req(int_req), .dac_cs_n(cs_n), .dac_sclk(sclk), .dac_din(din));
  bcdp_dac_model u_dac (.cs_n(cs_n), .sclk(sclk), .din(din), .synth_sclk(s_sclk),
    .pll_bit(pll_bit), .word(mword), .frames(frames));
  always #2.5 clk_sys = ~clk_sys;
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // a hung frame must not stall the run
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    cmp_count++;
    if ((got & m) !== (exp & m)) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got & m, exp & m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    chk(reg_rdata, e, m);
  endtask
  // one command: busy while sending, then word readback and far-side capture
  task automatic dac(input logic [15:0] w);
    f0 = frames;
    wr(8'h08, {16'h0000, w});
    rdc(8'h08, 32'h00010000, 32'h00010000);
    for (k = 0; k < 100 && cs_n !== 1'b1; k++) @(negedge clk_sys);
    rdc(8'h08, {16'h0000, w}, 32'h0001FFFF);
    chk({16'h0000, mword}, {16'h0000, w}, 32'h0000FFFF);
    chk(frames - f0, 32'h1, 32'hFFFFFFFF);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys) rst = 1'b0;
    rdc(8'h00, 32'h0, 32'h001F0033);
    rdc(8'h04, 32'h00005A3C, 32'h0009FFFF);
    rdc(8'h08, 32'h0, 32'h0001FFFF);
    rdc(8'h0C, 32'h0, 32'hFFFFFFFF);
    wr(8'h00, 32'h000F0003);
    chk({sd_oe_n, sd_o, s_aux, s_sclk, s_pgm, rb, ra}, 32'h3F, 32'h7F);
    rdc(8'h00, 32'h000F0003, 32'h000F0033);
    rdc(8'h04, 32'h00085A3C, 32'h0009FFFF);
    // released line: live bit comes from the far side, stored bit stays zero
    wr(8'h00, 32'h00130002);
    chk({sd_oe_n, sd_o, s_aux, s_sclk, s_pgm, rb, ra}, 32'h4E, 32'h7F);
    rdc(8'h00, 32'h000B0002, 32'h000F0033);
    rdc(8'h04, 32'h00005A3C, 32'h0009FFFF);
    for (i = 0; i < 4; i++) begin
      dip_sw = 8'hA5 ^ i[7:0];
      wr(8'h00, i << 4);
      chk({31'h0, int_req}, i == 3, 32'h1);
      rdc(8'h00, i << 4, 32'h00000030);
      rdc(8'h04, {15'h0, i == 3, 8'h5A, 8'hA5 ^ i[7:0]}, 32'h0001FFFF);
    end
    wr(8'h08, 32'h0000A5A4);
    repeat (9) @(negedge clk_sys);
    dac(16'h1FFC);
    for (i = 0; i < 11; i++) dac({i[3:0], 10'h2A5 ^ i[9:0], 2'b00});
    results();
  end
endmodule // bcdp_top_tb
bind bcdp_top bcdp_checker #(.LOGIC_REV(LOGIC_REV), .HALF_CYC(HALF_CYC)) u_chk (.*);
